/* File: tsxd_pkg.sv */
package tsxd_pkg;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [11:0] TSXD_CMD_OFS = 12'h000;
   localparam logic [11:0] TSXD_STAT_OFS = 12'h004;
   localparam logic [11:0] TSXD_ACC_OFS = 12'h008;
   localparam logic [11:0] TSXD_INFO_OFS = 12'h00c;
   localparam logic [11:0] TSXD_RF_BASE = 12'h100;
   localparam logic [11:0] TSXD_PF_BASE = 12'h200;
   localparam int TSXD_WIN_WORDS = 64;
   // ==========================================
   // Field positions
   localparam int TSXD_OPC_LSB = 0;
   localparam int TSXD_SRC_LSB = 8;
   localparam int TSXD_DST_LSB = 16;
   localparam int TSXD_B_LSB = 8;
   localparam int TSXD_BUSY_BIT = 0;
   localparam int TSXD_ILL_BIT = 1;
   localparam int TSXD_V_BIT = 4;
   localparam int TSXD_Z_BIT = 5;
   localparam int TSXD_N_BIT = 6;
   localparam int TSXD_C_BIT = 7;
   localparam int TSXD_BYTES_LSB = 8;
   localparam logic [7:0] TSXD_ACC_RST = 8'h00;
   localparam logic [7:0] TSXD_OPC_RST = 8'h00;
   // ==========================================
   // Operation codes
   localparam logic [7:0] OP_TEST_A = 8'hb0;
   localparam logic [7:0] OP_TEST_B = 8'hc6;
   localparam logic [7:0] OP_SWAP_A = 8'hb6;
   localparam logic [7:0] OP_SWAP_R = 8'hd6;
   localparam logic [7:0] OP_XOR_A_P = 8'h85;
   localparam logic [7:0] OP_XOR_B_A = 8'h65;
   localparam logic [7:0] OP_XOR_B_P = 8'h95;
   localparam logic [7:0] OP_XOR_R_A = 8'h15;
   localparam logic [7:0] OP_XOR_R_B = 8'h35;
   localparam logic [7:0] OP_XOR_R_R = 8'h45;
   localparam logic [7:0] OP_XOR_I_A = 8'h25;
   localparam logic [7:0] OP_XOR_I_B = 8'h55;
   localparam logic [7:0] OP_XOR_I_R = 8'h75;
   localparam logic [7:0] OP_XOR_I_P = 8'ha5;

   typedef enum logic {TSXD_IDLE = 1'b0, TSXD_RUN = 1'b1} tsxd_state_t;

   typedef struct packed {
      logic legal;
      logic [3:0] cycles;
      logic [1:0] bytes;
   } tsxd_dec_t;

   function automatic tsxd_dec_t tsxd_decode(input logic [7:0] op);
      tsxd_dec_t d;
      d = '{legal: 1'b1, cycles: 4'h0, bytes: 2'h1};
      case (op)
         OP_TEST_A: d.cycles = 4'h9;
         OP_TEST_B: d.cycles = 4'ha;
         OP_SWAP_A: d.cycles = 4'ha;
         OP_SWAP_R: begin d.cycles = 4'h8; d.bytes = 2'h2; end
         OP_XOR_A_P: begin d.cycles = 4'h9; d.bytes = 2'h2; end
         OP_XOR_B_A: d.cycles = 4'h8;
         OP_XOR_B_P: begin d.cycles = 4'h9; d.bytes = 2'h2; end
         OP_XOR_R_A: begin d.cycles = 4'h7; d.bytes = 2'h2; end
         OP_XOR_R_B: begin d.cycles = 4'h7; d.bytes = 2'h2; end
         OP_XOR_R_R: begin d.cycles = 4'h9; d.bytes = 2'h3; end
         OP_XOR_I_A: begin d.cycles = 4'h6; d.bytes = 2'h2; end
         OP_XOR_I_B: begin d.cycles = 4'h6; d.bytes = 2'h2; end
         OP_XOR_I_R: begin d.cycles = 4'h8; d.bytes = 2'h3; end
         OP_XOR_I_P: begin d.cycles = 4'ha; d.bytes = 2'h3; end
         default: begin d.legal = 1'b0; d.bytes = 2'h0; end
      endcase
      return d;
   endfunction
endpackage

/* File: tsxd_core.sv */
`timescale 1ns/1ps
// Summary of operation
// - Test A is B0, 9 cycles; B is C6, 10
// - Test clears C,V; N,Z from accumulator
// - Swap B with itself equals test B
// - Swap clears C,V; N,Z from old B
// - XOR result to destination, flags from result
// - Source ones invert destination bits
// - File-to-file XOR is 45, 3 bytes, 9 cycles
// - Immediate-to-peripheral XOR is A5, 10 cycles
module tsxd_core
   import tsxd_pkg::*;
#(
   parameter int RF_DEPTH = 16,
   parameter int PF_DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import tsxd_pkg::*;

   localparam int RW = $clog2(RF_DEPTH);
   localparam int PW = $clog2(PF_DEPTH);

   // Refused at elaboration: file indices are cut from low operand bits
   if (RF_DEPTH < 2 || RF_DEPTH > TSXD_WIN_WORDS ||
       (1 << RW) != RF_DEPTH || PF_DEPTH < 2 ||
       PF_DEPTH > TSXD_WIN_WORDS || (1 << PW) != PF_DEPTH) begin : g_depth
      $error("tsxd_core: depths must be powers of two, 2 to 64");
   end

   // ==========================================
   // State
   logic [7:0] a_q, b_q, op_q, src_q, dst_q;
   logic [7:0] rf_q [RF_DEPTH];
   logic [7:0] pf_q [PF_DEPTH];
   logic c_q, n_q, z_q, v_q, ill_q;
   logic [3:0] cnt_q, last_cyc_q;
   logic [1:0] last_bytes_q;
   tsxd_state_t state_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;

   // ==========================================
   // Bus decode
   logic acc, wr, rd, hit_rf, hit_pf, mapped;
   logic [RW-1:0] bus_ri;
   logic [PW-1:0] bus_pi;
   tsxd_dec_t dec;

   assign acc = psel & penable & pready_q;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   // Seven bits so that a full 64-word window does not wrap to zero
   assign hit_rf = paddr[11:8] == TSXD_RF_BASE[11:8] && paddr[1:0] == 2'b00
      && {1'b0, paddr[7:2]} < 7'(RF_DEPTH);
   assign hit_pf = paddr[11:8] == TSXD_PF_BASE[11:8] && paddr[1:0] == 2'b00
      && {1'b0, paddr[7:2]} < 7'(PF_DEPTH);
   assign mapped = hit_rf | hit_pf | paddr == TSXD_CMD_OFS |
      paddr == TSXD_STAT_OFS | paddr == TSXD_ACC_OFS |
      paddr == TSXD_INFO_OFS;
   assign bus_ri = paddr[RW+1:2];
   assign bus_pi = paddr[PW+1:2];
   assign dec = tsxd_decode(pwdata[TSXD_OPC_LSB +: 8]);

   // A command starts only when idle; later ones are dropped until done
   logic start, done;
   assign start = wr && paddr == TSXD_CMD_OFS && state_q == TSXD_IDLE;
   assign done = state_q == TSXD_RUN && cnt_q == 4'h0;

   // ==========================================
   // Operand fetch and result
   logic [RW-1:0] sri, dri;
   logic [PW-1:0] dpi;
   logic [7:0] s_val, d_val, res, flag_src;
   logic wr_a, wr_b, wr_r, wr_p;

   assign sri = src_q[RW-1:0];
   assign dri = dst_q[RW-1:0];
   assign dpi = dst_q[PW-1:0];

   always_comb begin
      s_val = 8'h00;
      d_val = 8'h00;
      wr_a = 1'b0;
      wr_b = 1'b0;
      wr_r = 1'b0;
      wr_p = 1'b0;
      case (op_q)
         OP_XOR_A_P: begin s_val = a_q; d_val = pf_q[dpi]; wr_p = 1'b1; end
         OP_XOR_B_A: begin s_val = b_q; d_val = a_q; wr_a = 1'b1; end
         OP_XOR_B_P: begin s_val = b_q; d_val = pf_q[dpi]; wr_p = 1'b1; end
         OP_XOR_R_A: begin s_val = rf_q[sri]; d_val = a_q; wr_a = 1'b1; end
         OP_XOR_R_B: begin s_val = rf_q[sri]; d_val = b_q; wr_b = 1'b1; end
         OP_XOR_R_R: begin
            s_val = rf_q[sri];
            d_val = rf_q[dri];
            wr_r = 1'b1;
         end
         OP_XOR_I_A: begin s_val = src_q; d_val = a_q; wr_a = 1'b1; end
         OP_XOR_I_B: begin s_val = src_q; d_val = b_q; wr_b = 1'b1; end
         OP_XOR_I_R: begin s_val = src_q; d_val = rf_q[dri]; wr_r = 1'b1; end
         OP_XOR_I_P: begin
            s_val = src_q;
            d_val = pf_q[dpi];
            wr_p = 1'b1;
         end
         default: begin end
      endcase
   end

   assign res = s_val ^ d_val;

   always_comb begin
      case (op_q)
         OP_TEST_A: flag_src = a_q;
         OP_TEST_B, OP_SWAP_A, OP_SWAP_R: flag_src = b_q;
         default: flag_src = res;
      endcase
   end

   // ==========================================
   // Sequencer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= TSXD_IDLE;
         cnt_q <= 4'h0;
      end else if (start && dec.legal) begin
         state_q <= TSXD_RUN;
         cnt_q <= dec.cycles - 4'h1;
      end else if (done) begin
         state_q <= TSXD_IDLE;
      end else if (state_q == TSXD_RUN) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         op_q <= TSXD_OPC_RST;
         src_q <= 8'h00;
         dst_q <= 8'h00;
         ill_q <= 1'b0;
         last_cyc_q <= 4'h0;
         last_bytes_q <= 2'h0;
      end else if (start) begin
         op_q <= pwdata[TSXD_OPC_LSB +: 8];
         src_q <= pwdata[TSXD_SRC_LSB +: 8];
         dst_q <= pwdata[TSXD_DST_LSB +: 8];
         ill_q <= ~dec.legal;
         last_cyc_q <= dec.cycles;
         last_bytes_q <= dec.bytes;
      end
   end

   // ==========================================
   // Flags: C and V always cleared by these operations
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         c_q <= 1'b0;
         n_q <= 1'b0;
         z_q <= 1'b0;
         v_q <= 1'b0;
      end else if (done) begin
         c_q <= 1'b0;
         v_q <= 1'b0;
         n_q <= flag_src[7];
         z_q <= flag_src == 8'h00;
      end
   end

   // ==========================================
   // Accumulators; bus writes land only while idle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         a_q <= TSXD_ACC_RST;
         b_q <= TSXD_ACC_RST;
      end else if (done) begin
         if (op_q == OP_SWAP_A) begin
            a_q <= b_q;
            b_q <= a_q;
         end else if (op_q == OP_SWAP_R) begin
            b_q <= rf_q[dri];
         end
         if (wr_a)
            a_q <= res;
         if (wr_b)
            b_q <= res;
      end else if (wr && paddr == TSXD_ACC_OFS && state_q == TSXD_IDLE) begin
         a_q <= pwdata[7:0];
         b_q <= pwdata[TSXD_B_LSB +: 8];
      end
   end

   // ==========================================
   // Register file and peripheral file
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < RF_DEPTH; i++)
            rf_q[i] <= 8'h00;
      end else if (done && op_q == OP_SWAP_R) begin
         rf_q[dri] <= b_q;
      end else if (done && wr_r) begin
         rf_q[dri] <= res;
      end else if (wr && hit_rf && state_q == TSXD_IDLE) begin
         rf_q[bus_ri] <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < PF_DEPTH; i++)
            pf_q[i] <= 8'h00;
      end else if (done && wr_p) begin
         pf_q[dpi] <= res;
      end else if (wr && hit_pf && state_q == TSXD_IDLE) begin
         pf_q[bus_pi] <= pwdata[7:0];
      end
   end

   // ==========================================
   // APB answer: one wait cycle so read data comes from a flop
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~mapped;
         prdata_q <= 32'h0000_0000;
         if (psel & penable & ~pready_q & ~pwrite) begin
            if (paddr == TSXD_CMD_OFS)
               prdata_q <= {8'h00, dst_q, src_q, op_q};
            else if (paddr == TSXD_STAT_OFS)
               prdata_q <= {24'h0, c_q, n_q, z_q, v_q, 2'b00, ill_q,
                  state_q == TSXD_RUN};
            else if (paddr == TSXD_ACC_OFS)
               prdata_q <= {16'h0, b_q, a_q};
            else if (paddr == TSXD_INFO_OFS)
               prdata_q <= {22'h0, last_bytes_q, 4'h0, last_cyc_q};
            else if (hit_rf)
               prdata_q <= {24'h0, rf_q[bus_ri]};
            else if (hit_pf)
               prdata_q <= {24'h0, pf_q[bus_pi]};
         end
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;
endmodule

/* File: tsxd_assertions.sv */
`timescale 1ns/1ps
module tsxd_assertions
   import tsxd_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ==========================================
   // Last accepted opcode, so that INFO reads can be judged
   logic [7:0] op_q;
   logic rd_stat;
   logic rd_info;
   assign rd_stat = pready && !pwrite && paddr == TSXD_STAT_OFS;
   assign rd_info = pready && !pwrite && paddr == TSXD_INFO_OFS;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         op_q <= 8'h00;
      end else if (pready && pwrite && paddr == TSXD_CMD_OFS) begin
         op_q <= pwdata[7:0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ==========================================
   // Bus timing, flags and INFO contents
   a_ready_late: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_phase: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error response");
   a_data_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero");
   a_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned accepted");
   a_flags_cv: assert property (rd_stat |->
      !prdata[TSXD_C_BIT] && !prdata[TSXD_V_BIT]) else $error("carry set");
   a_flags_nz: assert property (rd_stat && prdata[TSXD_Z_BIT] |->
      !prdata[TSXD_N_BIT]) else $error("zero and negative");
   a_info_file: assert property (rd_info && op_q == OP_XOR_R_R |->
      {prdata[9:8], prdata[3:0]} == 6'h39) else $error("file form info");
   a_info_imm: assert property (rd_info && op_q == OP_XOR_I_P |->
      {prdata[9:8], prdata[3:0]} == 6'h3a) else $error("imm form info");
   a_info_test: assert property (rd_info && op_q == OP_TEST_A |->
      {prdata[9:8], prdata[3:0]} == 6'h19) else $error("test info");
endmodule

/* File: test_exchange_xor_datapath_tb.sv */
`timescale 1ns/1ps
module test_exchange_xor_datapath_tb;
   import tsxd_pkg::*;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] s, r;
   int errors = 0;
   int checked = 0;
   int cyc = 0;
   logic [7:0] ops [10] = '{OP_XOR_A_P, OP_XOR_B_A, OP_XOR_B_P, OP_XOR_R_A,
      OP_XOR_R_B, OP_XOR_R_R, OP_XOR_I_A, OP_XOR_I_B, OP_XOR_I_R, OP_XOR_I_P};
   int sk [10] = '{0, 1, 1, 2, 2, 2, 4, 4, 4, 4};
   int dk [10] = '{3, 0, 3, 0, 1, 2, 0, 1, 2, 3};
   int cy [10] = '{9, 8, 9, 7, 7, 9, 6, 6, 8, 10};
   logic [7:0] bv [5] = '{8'h5a, 8'hc3, 8'hf0, 8'h99, 8'h5a};
   logic [11:0] da [4] = '{TSXD_ACC_OFS, TSXD_ACC_OFS, TSXD_RF_BASE + 12'h8,
      TSXD_PF_BASE + 12'h8};
   tsxd_core u_dut (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) cyc <= cyc + 1;
   // ==========================================
   // Bus and compare tasks
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(exp, q);
   endtask
   function automatic logic [31:0] fl(input logic [7:0] v);
      return {24'h0, 1'b0, v[7], v == 8'h00, 5'h0};
   endfunction
   // Status is captured one edge before pready is seen; the last busy
   // sample and the first idle one must bracket the cycle count
   task automatic run(input logic [31:0] cmd, input int n,
         input logic [7:0] v);
      int t0;
      int k;
      int kb;
      apb(1'b1, TSXD_CMD_OFS, cmd);
      t0 = cyc;
      k = 0;
      do begin
         kb = k;
         apb(1'b0, TSXD_STAT_OFS, 32'h0);
         k = cyc - 1 - t0;
      end while (q[TSXD_BUSY_BIT] !== 1'b0 && k < 80);
      chk(32'h1, {31'h0, kb <= n && k >= n + 1});
      chk(fl(v), q);
      apb(1'b0, TSXD_INFO_OFS, 32'h0);
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 44'h0};
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rd_chk(TSXD_ACC_OFS, 32'h0);
      rd_chk(TSXD_STAT_OFS, 32'h0);
      $display("reset test done");
      apb(1'b1, TSXD_ACC_OFS, 32'h0080);
      run({24'h0, OP_TEST_A}, 9, 8'h80);
      run({24'h0, OP_TEST_B}, 10, 8'h00);
      rd_chk(TSXD_ACC_OFS, 32'h0080);
      apb(1'b1, TSXD_ACC_OFS, 32'ha53c);
      run({24'h0, OP_SWAP_A}, 10, 8'ha5);
      rd_chk(TSXD_ACC_OFS, 32'h3ca5);
      apb(1'b1, TSXD_RF_BASE + 12'hc, 32'h0);
      run({16'h0003, 8'h00, OP_SWAP_R}, 8, 8'h3c);
      rd_chk(TSXD_RF_BASE + 12'hc, 32'h3c);
      rd_chk(TSXD_ACC_OFS, 32'h00a5);
      $display("test and swap done");
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, TSXD_ACC_OFS, 32'hc35a);
         apb(1'b1, TSXD_RF_BASE + 12'h4, 32'h0f);
         apb(1'b1, TSXD_RF_BASE + 12'h8, 32'hf0);
         apb(1'b1, TSXD_PF_BASE + 12'h8, 32'h99);
         s = (sk[i] == 2) ? 8'h0f : bv[sk[i]];
         r = s ^ bv[dk[i]];
         run({16'h02, (sk[i] == 2) ? 8'h01 : s, ops[i]}, cy[i], r);
         apb(1'b0, da[dk[i]], 32'h0);
         chk({24'h0, r}, {24'h0, dk[i] == 1 ? q[15:8] : q[7:0]});
      end
      $display("exclusive or done");
      apb(1'b1, TSXD_CMD_OFS, 32'hff);
      rd_chk(TSXD_STAT_OFS, 32'h2 | fl(8'hc3));
      apb(1'b0, 12'h010, 32'h0);
      chk({32'h1}, {31'h0, e});
      apb(1'b1, TSXD_RF_BASE + 12'h1, 32'h77);
      chk({32'h1}, {31'h0, e});
      $display("error test done");
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      $display("Watchdog expired");
      final_report();
   end
endmodule
bind tsxd_core tsxd_assertions u_chk (.clock(clock), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
